// ---- src/nrds_pkg.sv ----
// constants shared by the divide datapath and its register bus
package nrds_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_REG0 = 8'h00;
  localparam logic [7:0] OFF_REG1 = 8'h04;
  localparam logic [7:0] OFF_REG2 = 8'h08;
  localparam logic [7:0] OFF_REG3 = 8'h0C;
  localparam logic [7:0] OFF_QUO = 8'h10;
  localparam logic [7:0] OFF_UCODE = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // microword field positions
  localparam int UC_SRC_LSB = 0;
  localparam int UC_FUN_LSB = 3;
  localparam int UC_DST_LSB = 6;
  localparam int UC_CIN_BIT = 9;
  localparam int UC_FORCE_BIT = 10;
  localparam int UC_CSIGN_BIT = 11;
  localparam int UC_FILL_BIT = 12;
  localparam int UC_CSRC1_BIT = 13;
  localparam int UC_A_LSB = 14;
  localparam int UC_B_LSB = 16;
  localparam int UC_W = 18;
  // status field positions
  localparam int ST_SIGN_BIT = 0;
  localparam int ST_PREV_BIT = 1;
  localparam int ST_CARRY_BIT = 2;
  localparam int ST_ZERO_BIT = 3;
  // reset values
  localparam logic [31:0] RST_RDATA = 32'h00000000;
  localparam logic [UC_W-1:0] RST_UCODE = 18'h00040;
  // function codes
  localparam logic [2:0] FN_ADD = 3'h0;
  localparam logic [2:0] FN_SUBR = 3'h1;
  localparam logic [2:0] FN_SUBS = 3'h2;
  localparam logic [2:0] FN_OR = 3'h3;
  localparam logic [2:0] FN_AND = 3'h4;
  localparam logic [2:0] FN_NOTRS = 3'h5;
  localparam logic [2:0] FN_XOR = 3'h6;
  localparam logic [2:0] FN_XNOR = 3'h7;
  // destination codes
  localparam logic [2:0] DST_QREG = 3'h0;
  localparam logic [2:0] DST_NOP = 3'h1;
  localparam logic [2:0] DST_RAMA = 3'h2;
  localparam logic [2:0] DST_RAMF = 3'h3;
  localparam logic [2:0] DST_RAMQD = 3'h4;
  localparam logic [2:0] DST_RAMD = 3'h5;
  localparam logic [2:0] DST_RAMQU = 3'h6;
  localparam logic [2:0] DST_RAMU = 3'h7;
endpackage

// ---- src/nrds_top.sv ----
// divide datapath: working registers, quotient shifter, status, ahb-lite
// How it works
// - the OR result's top bit is captured in the status register.
// - a down shift with status fill enabled restores the sign bit.
// - force subtract drives function bit 0 and carry in high.
// - each DST_RAMQU up shift latches the sign and shifts its complement into Q.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
module nrds_top #(
  parameter int W = nrds_pkg::DATA_W
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [nrds_pkg::ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);
  typedef struct packed {
    logic [3:0][W-1:0] regs;
    logic [W-1:0] quo;
    logic [nrds_pkg::UC_W-1:0] ucode;
    logic sign;
    logic prev;
    logic carry;
    logic zero;
    logic wr_pend;
    logic rd_pend;
    logic [nrds_pkg::ADDR_W-1:0] dph_addr;
    logic [31:0] rdata;
    logic readyout;
  } nrds_state_t;

  nrds_state_t st;
  nrds_state_t next_st;

  logic [nrds_pkg::UC_W-1:0] uw;
  logic [2:0] src;
  logic [2:0] fn;
  logic [2:0] dst;
  logic cin;
  logic [1:0] a_sel;
  logic [1:0] b_sel;
  logic [W-1:0] ra;
  logic [W-1:0] rb;
  logic [W-1:0] op_r;
  logic [W-1:0] op_s;
  logic [W:0] sum;
  logic [W-1:0] f;
  logic f_msb;
  logic fill;
  logic exec;
  logic accept;
  logic [31:0] rd_mux;

  assign accept = HSEL && HTRANS[1] && HREADY;
  assign exec = st.wr_pend && HREADY &&
                (st.dph_addr == nrds_pkg::OFF_UCODE);
  assign uw = HWDATA[nrds_pkg::UC_W-1:0];
  assign a_sel = uw[nrds_pkg::UC_A_LSB +: 2];
  assign b_sel = uw[nrds_pkg::UC_B_LSB +: 2];
  assign dst = uw[nrds_pkg::UC_DST_LSB +: 3];
  assign ra = st.regs[a_sel];
  assign rb = st.regs[b_sel];

  // carry and function bit 0 steering
  always_comb begin
    fn = uw[nrds_pkg::UC_FUN_LSB +: 3];
    src = uw[nrds_pkg::UC_SRC_LSB +: 3];
    cin = uw[nrds_pkg::UC_CIN_BIT];
    if (uw[nrds_pkg::UC_FORCE_BIT]) begin
      fn[0] = 1'b1;
      cin = 1'b1;
    end else if (uw[nrds_pkg::UC_CSIGN_BIT]) begin
      fn[0] = ~st.sign;
      cin = ~st.sign;
    end
    if (uw[nrds_pkg::UC_CSRC1_BIT]) begin
      src[1] = ~st.sign;
    end
  end

  // operand selection; external data port reads as zero
  always_comb begin
    op_r = '0;
    op_s = '0;
    case (src)
      3'h0: begin
        op_r = ra;
        op_s = st.quo;
      end
      3'h1: begin
        op_r = ra;
        op_s = rb;
      end
      3'h2: op_s = st.quo;
      3'h3: op_s = rb;
      3'h4: op_s = ra;
      3'h5: op_s = ra;
      3'h6: op_s = st.quo;
      default: op_s = '0;
    endcase
  end

  always_comb begin
    sum = '0;
    case (fn)
      nrds_pkg::FN_ADD: sum = {1'b0, op_r} + {1'b0, op_s} + {{W{1'b0}}, cin};
      nrds_pkg::FN_SUBR: sum = {1'b0, op_s} + {1'b0, ~op_r} +
                               {{W{1'b0}}, cin};
      nrds_pkg::FN_SUBS: sum = {1'b0, op_r} + {1'b0, ~op_s} +
                               {{W{1'b0}}, cin};
      nrds_pkg::FN_OR: sum = {1'b0, op_r | op_s};
      nrds_pkg::FN_AND: sum = {1'b0, op_r & op_s};
      nrds_pkg::FN_NOTRS: sum = {1'b0, ~op_r & op_s};
      nrds_pkg::FN_XOR: sum = {1'b0, op_r ^ op_s};
      default: sum = {1'b0, ~(op_r ^ op_s)};
    endcase
  end

  assign f = sum[W-1:0];
  assign f_msb = f[W-1];
  // old status bit refills the top on a down shift when enabled
  assign fill = uw[nrds_pkg::UC_FILL_BIT] & st.sign;

  always_comb begin
    rd_mux = '0;
    if (st.dph_addr == nrds_pkg::OFF_REG0) begin
      rd_mux[W-1:0] = st.regs[0];
    end else if (st.dph_addr == nrds_pkg::OFF_REG1) begin
      rd_mux[W-1:0] = st.regs[1];
    end else if (st.dph_addr == nrds_pkg::OFF_REG2) begin
      rd_mux[W-1:0] = st.regs[2];
    end else if (st.dph_addr == nrds_pkg::OFF_REG3) begin
      rd_mux[W-1:0] = st.regs[3];
    end else if (st.dph_addr == nrds_pkg::OFF_QUO) begin
      rd_mux[W-1:0] = st.quo;
    end else if (st.dph_addr == nrds_pkg::OFF_UCODE) begin
      rd_mux[nrds_pkg::UC_W-1:0] = st.ucode;
    end else if (st.dph_addr == nrds_pkg::OFF_STATUS) begin
      rd_mux[nrds_pkg::ST_SIGN_BIT] = st.sign;
      rd_mux[nrds_pkg::ST_PREV_BIT] = st.prev;
      rd_mux[nrds_pkg::ST_CARRY_BIT] = st.carry;
      rd_mux[nrds_pkg::ST_ZERO_BIT] = st.zero;
    end
  end

  always_comb begin
    next_st = st;
    // data phase of a write
    if (st.wr_pend && HREADY) begin
      next_st.wr_pend = 1'b0;
      if (st.dph_addr == nrds_pkg::OFF_REG0) begin
        next_st.regs[0] = HWDATA[W-1:0];
      end else if (st.dph_addr == nrds_pkg::OFF_REG1) begin
        next_st.regs[1] = HWDATA[W-1:0];
      end else if (st.dph_addr == nrds_pkg::OFF_REG2) begin
        next_st.regs[2] = HWDATA[W-1:0];
      end else if (st.dph_addr == nrds_pkg::OFF_REG3) begin
        next_st.regs[3] = HWDATA[W-1:0];
      end else if (st.dph_addr == nrds_pkg::OFF_QUO) begin
        next_st.quo = HWDATA[W-1:0];
      end
    end
    // one microcycle per microword write
    if (exec) begin
      next_st.ucode = uw;
      next_st.sign = f_msb;
      next_st.prev = st.sign;
      next_st.carry = sum[W];
      next_st.zero = (f == '0);
      case (dst)
        nrds_pkg::DST_QREG: next_st.quo = f;
        nrds_pkg::DST_NOP: next_st.quo = st.quo;
        nrds_pkg::DST_RAMA: next_st.regs[b_sel] = f;
        nrds_pkg::DST_RAMF: next_st.regs[b_sel] = f;
        nrds_pkg::DST_RAMQD: begin
          next_st.regs[b_sel] = {fill, f[W-1:1]};
          next_st.quo = {1'b0, st.quo[W-1:1]};
        end
        nrds_pkg::DST_RAMD: next_st.regs[b_sel] = {fill, f[W-1:1]};
        nrds_pkg::DST_RAMQU: begin
          next_st.regs[b_sel] = {f[W-2:0], 1'b0};
          next_st.quo = {st.quo[W-2:0], ~f_msb};
        end
        default: next_st.regs[b_sel] = {f[W-2:0], 1'b0};
      endcase
    end
    // read takes one wait state so earlier writes are visible
    if (st.rd_pend) begin
      next_st.rd_pend = 1'b0;
      next_st.rdata = rd_mux;
      next_st.readyout = 1'b1;
    end
    if (accept) begin
      next_st.dph_addr = HADDR;
      next_st.wr_pend = HWRITE;
      next_st.rd_pend = ~HWRITE;
      next_st.readyout = HWRITE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st <= '0;
      st.ucode <= nrds_pkg::RST_UCODE;
      st.rdata <= nrds_pkg::RST_RDATA;
      st.readyout <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign HRDATA = st.rdata;
  assign HREADYOUT = st.readyout;
  assign HRESP = 1'b0;

  // checks
  logic fn_or;
  logic [W-1:0] diff_ba;
  logic rb_msb;
  assign fn_or = (uw[nrds_pkg::UC_FUN_LSB +: 3] == nrds_pkg::FN_OR) &&
                 !uw[nrds_pkg::UC_FORCE_BIT] && !uw[nrds_pkg::UC_CSIGN_BIT];
  assign diff_ba = rb - ra;
  assign rb_msb = rb[W-1];

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  AST_OR_CAPTURE: assert property (
    exec && fn_or && (src == 3'h3) |=> st.sign == $past(rb_msb))
    else $error("or result msb not captured in status");
  AST_FORCE_SUB: assert property (
    exec && uw[nrds_pkg::UC_FORCE_BIT] && (src == 3'h1) &&
    (uw[nrds_pkg::UC_FUN_LSB +: 3] == nrds_pkg::FN_ADD) &&
    (dst == nrds_pkg::DST_RAMF) |=> st.regs[$past(b_sel)] == $past(diff_ba))
    else $error("forced subtract did not give b minus a");
  AST_SIGN_RESTORE: assert property (
    exec && (dst == nrds_pkg::DST_RAMD) && uw[nrds_pkg::UC_FILL_BIT]
    |=> st.regs[$past(b_sel)][W-1] == st.prev)
    else $error("down shift did not restore sign bit");
  AST_QUO_FILL: assert property (
    exec && (dst == nrds_pkg::DST_RAMQU)
    |=> (st.quo[0] == ~st.sign) && (st.regs[$past(b_sel)][0] == 1'b0))
    else $error("quotient lsb is not the inverted sign");
  AST_READ_WAIT: assert property (
    accept && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state missing");
endmodule // nrds_top

// ---- test/nrds_seq_model.sv ----
// divide sequencer model: ahb-lite master issuing microwords
module nrds_seq_model (
  input wire logic MCLK,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  output logic HSEL,
  output logic [7:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [31:0] HWDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rdy_n;
  logic [31:0] rdat_n;
  initial begin
    HSEL = 1'b0;
    HADDR = 8'h00;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h00000000;
  end
  // slave outputs move only at rising edges, so this is the sampled value
  always @(negedge MCLK) begin
    rdy_n <= HREADY;
    rdat_n <= HRDATA;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge MCLK);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge MCLK); while (rdy_n !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= w ? wd : ~HWDATA;
    do @(posedge MCLK); while (rdy_n !== 1'b1);
    rd = rdat_n;
  endtask
  function automatic logic [31:0] uc(input logic [2:0] sr, fn, ds,
    input logic [4:0] fl, input logic [1:0] a, b);
    return {14'h0000, b, a, fl, ds, fn, sr};
  endfunction
  task automatic op(input logic [31:0] u);
    logic [31:0] d;
    xfer(1'b1, nrds_pkg::OFF_UCODE, u, d);
  endtask
  task automatic divide(input logic [15:0] x, y, output logic [31:0] q, r);
    logic [31:0] d;
    logic sx, sy, p, s;
    int k;
    k = 0;
    xfer(1'b1, nrds_pkg::OFF_QUO, 32'h00000000, d);
    xfer(1'b1, nrds_pkg::OFF_REG0, {16'h0000, x}, d);
    xfer(1'b1, nrds_pkg::OFF_REG1, {16'h0000, y}, d);
    xfer(1'b0, nrds_pkg::OFF_REG0, 32'h00000000, d);
    sx = d[15];
    xfer(1'b0, nrds_pkg::OFF_REG1, 32'h00000000, d);
    sy = d[15];
    if (sx) op(uc(3'h3, 3'h2, 3'h3, 5'h01, 2'h0, 2'h0));
    if (sy) op(uc(3'h4, 3'h2, 3'h3, 5'h01, 2'h1, 2'h1));
    op(uc(3'h3, 3'h3, 3'h1, 5'h00, 2'h0, 2'h1));
    do begin
      xfer(1'b0, nrds_pkg::OFF_REG1, 32'h00000000, d);
      p = d[15];
      xfer(1'b0, nrds_pkg::OFF_STATUS, 32'h00000000, d);
      s = d[nrds_pkg::ST_SIGN_BIT];
      op(uc(3'h3, 3'h3, {1'b1, ~(p ^ s), 1'b1}, 5'h08, 2'h0,
        2'h1));
      k = (p == s) ? k + 1 : k - 1;
    end while (p == s);
    for (int i = 0; i <= k; i++) begin
      if (i < k) begin
        op(uc(3'h1, 3'h0, 3'h6, (i == 0) ? 5'h02 : 5'h04, 2'h1,
          2'h0));
      end else begin
        // last step keeps the unshifted remainder; q shifts via scratch reg3
        op(uc(3'h1, 3'h0, 3'h3, (i == 0) ? 5'h02 : 5'h04, 2'h1,
          2'h0));
        op(uc(3'h4, 3'h3, 3'h6, 5'h00, 2'h0, 2'h3));
      end
    end
    op(uc(3'h1, 3'h0, 3'h3, 5'h10, 2'h1, 2'h0));
    repeat (k) op(uc(3'h3, 3'h3, 3'h5, 5'h00, 2'h0, 2'h0));
    if (sx ^ sy) op(uc(3'h2, 3'h2, 3'h0, 5'h01, 2'h0, 2'h0));
    if (sx) op(uc(3'h3, 3'h2, 3'h3, 5'h01, 2'h0, 2'h0));
    xfer(1'b0, nrds_pkg::OFF_QUO, 32'h00000000, q);
    xfer(1'b0, nrds_pkg::OFF_REG0, 32'h00000000, r);
  endtask
endmodule // nrds_seq_model

// ---- test/tb_nonrestoring_divide_sequencer.sv ----
// self-checking bench: signed divisions driven through the microword port
module tb_nonrestoring_divide_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic HSEL, HWRITE, HREADYOUT, HRESP;
  logic [7:0] HADDR;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HWDATA, HRDATA, q, r, d;
  logic signed [15:0] a, b;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 38347;
  always #2 MCLK = ~MCLK;
  nrds_top uut (.MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP));
  nrds_seq_model seq (.MCLK(MCLK), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA));
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // expected alu result with carry in low, per source and function code
  function automatic logic [15:0] alu(input logic [2:0] sr, fn,
    input logic [15:0] av, bv, qv);
    logic [15:0] rv;
    logic [15:0] sv;
    rv = (sr < 3'h2) ? av : 16'h0000;
    case (sr)
      3'h0, 3'h2, 3'h6: sv = qv;
      3'h1, 3'h3: sv = bv;
      3'h4, 3'h5: sv = av;
      default: sv = 16'h0000;
    endcase
    case (fn)
      3'h0: return rv + sv;
      3'h1: return sv + ~rv;
      3'h2: return rv + ~sv;
      3'h3: return rv | sv;
      3'h4: return rv & sv;
      3'h5: return ~rv & sv;
      3'h6: return rv ^ sv;
      default: return ~(rv ^ sv);
    endcase
  endfunction
  task automatic run(input logic signed [15:0] x, y);
    logic signed [15:0] eq, er;
    eq = x / y;
    er = x % y;
    seq.divide(x, y, q, r);
    check("quotient", q, {16'h0000, eq});
    check("remainder", r, {16'h0000, er});
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge MCLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seq.xfer(1'b0, 8'(i * 4), 32'h00000000, d);
      check("reset value", d, (8'(i * 4) == nrds_pkg::OFF_UCODE) ?
        32'(nrds_pkg::RST_UCODE) : 32'h00000000);
    end
    seq.xfer(1'b1, 8'h1C, 32'hFFFFFFFF, d);
    seq.xfer(1'b1, nrds_pkg::OFF_STATUS, 32'hFFFFFFFF, d);
    seq.xfer(1'b1, nrds_pkg::OFF_REG2, 32'hA5A5FFFF, d);
    seq.xfer(1'b0, 8'h1C, 32'h00000000, d);
    check("unmapped", d, 32'h00000000);
    seq.xfer(1'b0, nrds_pkg::OFF_STATUS, 32'h00000000, d);
    check("status ro", d, 32'h00000000);
    seq.xfer(1'b0, nrds_pkg::OFF_REG2, 32'h00000000, d);
    check("reg2", d, 32'h0000FFFF);
    // 0 + ffff + 1 wraps to zero with carry out
    seq.op(seq.uc(3'h3, 3'h0, 3'h1, 5'h01, 2'h0, 2'h2));
    seq.xfer(1'b0, nrds_pkg::OFF_STATUS, 32'h00000000, d);
    check("flags add", d, 32'h0000000C);
    seq.op(seq.uc(3'h3, 3'h3, 3'h1, 5'h00, 2'h0, 2'h2));
    seq.xfer(1'b0, nrds_pkg::OFF_STATUS, 32'h00000000, d);
    check("flags or", d, 32'h00000001);
    // down shift with a set status sign must refill the top bit
    seq.op(seq.uc(3'h3, 3'h3, 3'h5, 5'h08, 2'h0, 2'h2));
    seq.xfer(1'b0, nrds_pkg::OFF_REG2, 32'h00000000, d);
    check("sign fill", d, 32'h0000FFFF);
    seq.xfer(1'b0, nrds_pkg::OFF_UCODE, 32'h00000000, d);
    check("ucode", d, seq.uc(3'h3, 3'h3, 3'h5, 5'h08, 2'h0, 2'h2));
    // every source and function code once, result routed to q
    for (int sr = 0; sr < 8; sr++) begin
      for (int fc = 0; fc < 8; fc++) begin
        a = 16'($random(seed));
        b = 16'($random(seed));
        seq.xfer(1'b1, nrds_pkg::OFF_REG2, {16'h0000, a}, d);
        seq.xfer(1'b1, nrds_pkg::OFF_REG3, {16'h0000, b}, d);
        seq.xfer(1'b1, nrds_pkg::OFF_QUO, {16'h0000, a[7:0], b[15:8]}, d);
        seq.op(seq.uc(3'(sr), 3'(fc), 3'h0, 5'h00, 2'h2, 2'h3));
        seq.xfer(1'b0, nrds_pkg::OFF_QUO, 32'h00000000, d);
        check("alu", d,
          {16'h0000, alu(3'(sr), 3'(fc), a, b, {a[7:0], b[15:8]})});
      end
    end
    run(16'sd7, 16'sd2);
    run(-16'sd7, 16'sd2);
    run(16'sd7, -16'sd2);
    run(-16'sd7, -16'sd2);
    run(16'sd0, 16'sd5);
    run(16'sd32767, 16'sd1);
    run(16'sd1, 16'sd32767);
    run(16'sd100, 16'sd100);
    run(-16'sd32767, 16'sd16384);
    repeat (20) begin
      a = 16'($random(seed) % 32768);
      b = 16'($random(seed) % 32768);
      if (b == 16'sd0) b = 16'sd1;
      run(a, b);
    end
    check("hresp", {31'h00000000, HRESP}, 32'h00000000);
    stop_test();
  end
endmodule // tb_nonrestoring_divide_sequencer
